// File: common/eil_pkg.sv
// package of constants and types for the external request pin interrupt unit
package eil_pkg;

  // ==========================================================
  // register bus geometry
  localparam int ADDR_W = 4;
  localparam int DATA_W = 8;

  // ==========================================================
  // register offsets
  localparam logic [3:0] OFS_CTRL = 4'h0; // timer_irq_control_reg
  localparam logic [3:0] OFS_CFG = 4'h1; // enables, priorities, power-down
  localparam logic [3:0] OFS_STAT = 4'h2; // sequencer status, read only

  // ==========================================================
  // timer_irq_control_reg field positions
  localparam int BIT_TRIG_A = 0; // 1 = edge, 0 = level
  localparam int BIT_FLAG_A = 1; // ext_req_flag_a
  localparam int BIT_TRIG_B = 2; // 1 = edge, 0 = level
  localparam int BIT_FLAG_B = 3; // ext_req_flag_b

  // ==========================================================
  // configuration register field positions
  localparam int BIT_EN_A = 0; // source a enable
  localparam int BIT_EN_B = 1; // source b enable
  localparam int BIT_PRIO_A = 2; // source a high priority
  localparam int BIT_PRIO_B = 3; // source b high priority
  localparam int BIT_PD = 4; // power-down request / state

  // ==========================================================
  // status register field positions
  localparam int BIT_CALLING = 0; // vector call in progress
  localparam int BIT_SVC_LO = 1; // low priority routine active
  localparam int BIT_SVC_HI = 2; // high priority routine active
  localparam int BIT_SRC = 3; // source of last vector, 1 = b
  localparam int BIT_PD_ST = 4; // powered down

  // ==========================================================
  // reset values
  localparam logic [7:0] RST_CTRL = 8'h00;
  localparam logic [7:0] RST_CFG = 8'h00;
  localparam logic PIN_IDLE = 1'b1; // pins idle high, active low

  // ==========================================================
  // timing: clock period in ns, the rest in clock cycles
  localparam int CLK_PERIOD_NS = 40;
  localparam int DETECT_CYC = 1; // polling cycle
  localparam int CALL_CYC = 4; // hardware_vector_call length
  localparam int MIN_RESPONSE_CYC = DETECT_CYC + CALL_CYC;
  localparam int MAX_RESPONSE_CYC = 16;
  localparam logic [1:0] CALL_LAST = 2'(CALL_CYC - 1);

  // ==========================================================
  // types
  typedef struct packed {
    logic [ADDR_W-1:0] addr; // register offset
    logic [DATA_W-1:0] wdata; // write data
    logic wr; // write strobe
    logic rd; // read strobe
  } eil_bus_req_s;

  typedef struct packed {
    logic low; // synchronised pin is low
    logic fall; // high-to-low seen on two samples
  } eil_pin_smp_s;

  typedef struct packed {
    logic s1; // first synchroniser stage
    logic s2; // second synchroniser stage
    logic prev; // previous synchronised sample
  } eil_smp_state_s;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_CALL = 2'b10
  } eil_state_e;

  typedef struct packed {
    eil_state_e st; // vector sequencer state
    logic [1:0] cnt; // call cycle counter
    logic trig_a; // trig_type_a
    logic trig_b; // trig_type_b
    logic flag_a; // ext_req_flag_a
    logic flag_b; // ext_req_flag_b
    logic en_a; // source a enable
    logic en_b; // source b enable
    logic prio_a; // source a priority
    logic prio_b; // source b priority
    logic pd; // power-down
    logic svc_lo; // low priority routine running
    logic svc_hi; // high priority routine running
    logic vprio; // priority of the vector being called
    logic src; // selected source, 1 = b
    logic start; // service routine start pulse
    logic insvc; // any routine running
    logic [1:0] pend; // requests presented to the core
    logic [DATA_W-1:0] rdata; // read data
  } eil_core_s;

endpackage : eil_pkg

// File: design/eil_pin_sampler.sv
// two-flop synchroniser and falling edge sampler for one request pin
module eil_pin_sampler (
  input wire logic clk_i, // system clock
  input wire logic arst_n_i, // asynchronous reset, active low
  input wire logic pin_i, // asynchronous request pin
  output eil_pkg::eil_pin_smp_s smp_o // synchronised level and edge
);
  import eil_pkg::*;

  // ==========================================================
  // state
  eil_smp_state_s q_ff; // registered state
  eil_smp_state_s nxt_q; // next state

  // ==========================================================
  // next state: s1 feeds only s2, all logic looks at s2 and prev
  always_comb begin
    nxt_q = q_ff;
    nxt_q.s1 = pin_i;
    nxt_q.s2 = q_ff.s1;
    nxt_q.prev = q_ff.s2;
  end

  // reset to the idle level so release never fakes an edge
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      q_ff <= '{s1: PIN_IDLE, s2: PIN_IDLE, prev: PIN_IDLE};
    end else begin
      q_ff <= nxt_q;
    end
  end

  // ==========================================================
  // outputs
  // [RULE_07] sample per clock, high then low
  // [RULE_08] pulses narrower than a clock may be missed
  assign smp_o.low = ~q_ff.s2;
  assign smp_o.fall = q_ff.prev & ~q_ff.s2;

endmodule // eil_pin_sampler

// File: design/eil_ext_irq_unit.sv
// external request pin interrupt unit with vector call sequencer
// Function
// [RULE_01] service starts at least 5 cycles after flag
// [RULE_02] single source starts within 16 cycles
// [RULE_03] one detect cycle, four call cycles
// [RULE_04] poll only in instruction's last cycle
// [RULE_05] equal or higher routine running blocks vectoring
// [RULE_06] per-pin bit selects edge or level
// [RULE_07] edge mode flags a high-then-low sample pair
// [RULE_08] source holds each level one clock minimum
// [RULE_09] edge flag cleared by hardware on vectoring
// [RULE_10] level flag equals inverted pin, never hardware-cleared
// [RULE_11] level source holds pin low until serviced
// [RULE_12] pin still low after return requests again
// [RULE_13] either pin wakes from power-down
// [RULE_14] request reaches core only when flagged and enabled
//
// Design decisions made here: the strobed register port and the placing of the registers.
module eil_ext_irq_unit (
  input wire logic clk_i, // system clock, 25 MHz
  input wire logic arst_n_i, // asynchronous reset, active low
  input eil_pkg::eil_bus_req_s bus_req_i, // register access
  output logic [eil_pkg::DATA_W-1:0] rdata_o, // read data, cycle after rd
  input wire logic ext_req_pin_a_i, // request pin a, active low
  input wire logic ext_req_pin_b_i, // request pin b, active low
  input wire logic instr_end_i, // core: last cycle of instruction
  input wire logic ret_service_i, // core: return_from_service_instr done
  output logic isr_start_o, // pulse: service routine begins
  output logic isr_src_o, // source of that routine, 1 = b
  output logic [1:0] irq_pending_o, // {b, a} enabled requests
  output logic in_service_o, // a routine is running
  output logic power_down_o // device is powered down
);
  import eil_pkg::*;

  // ==========================================================
  // pin samplers
  eil_pin_smp_s smp_a; // pin a level and edge
  eil_pin_smp_s smp_b; // pin b level and edge

  eil_pin_sampler u_smp_a (
    .clk_i(clk_i),
    .arst_n_i(arst_n_i),
    .pin_i(ext_req_pin_a_i),
    .smp_o(smp_a)
  );

  eil_pin_sampler u_smp_b (
    .clk_i(clk_i),
    .arst_n_i(arst_n_i),
    .pin_i(ext_req_pin_b_i),
    .smp_o(smp_b)
  );

  // ==========================================================
  // helper functions
  // next flag value; in edge mode the set beats both clears
  function automatic logic nxt_flag(input logic edge_mode, input logic fall,
                                    input logic low, input logic hw_clr,
                                    input logic wr, input logic wbit,
                                    input logic cur);
    logic kept;
    kept = wr ? wbit : cur;
    // [RULE_06] trigger type selects the flag source
    if (edge_mode) begin
      nxt_flag = fall | (kept & ~hw_clr);
    end else begin
      nxt_flag = low;
    end
  endfunction

  // a request may vector only above every running routine
  function automatic logic can_take(input logic prio, input logic lo,
                                    input logic hi);
    can_take = prio ? ~hi : ~(hi | lo);
  endfunction

  // ==========================================================
  // state
  eil_core_s q_ff; // registered state
  eil_core_s nxt_q; // next state
  logic wr_ctrl; // write to timer_irq_control_reg
  logic wr_cfg; // write to configuration register
  logic elig_a; // source a may vector now
  logic elig_b; // source b may vector now
  logic sel_b; // source b chosen
  logic take; // polling cycle accepts a request
  logic hw_clr_a; // vector clears flag a
  logic hw_clr_b; // vector clears flag b

  // ==========================================================
  // next state logic
  always_comb begin
    nxt_q = q_ff;
    nxt_q.start = 1'b0;
    nxt_q.rdata = '0;
    hw_clr_a = 1'b0;
    hw_clr_b = 1'b0;
    wr_ctrl = bus_req_i.wr && (bus_req_i.addr == OFS_CTRL);
    wr_cfg = bus_req_i.wr && (bus_req_i.addr == OFS_CFG);
    // [RULE_05] running routines gate eligibility
    elig_a = q_ff.flag_a && q_ff.en_a && can_take(q_ff.prio_a, q_ff.svc_lo, q_ff.svc_hi);
    elig_b = q_ff.flag_b && q_ff.en_b && can_take(q_ff.prio_b, q_ff.svc_lo, q_ff.svc_hi);
    // fixed order: a wins unless only b is high priority
    sel_b = elig_b && (!elig_a || (q_ff.prio_b && !q_ff.prio_a));
    // [RULE_04] poll only on the last instruction cycle
    take = (q_ff.st == ST_IDLE) && !q_ff.pd && instr_end_i && (elig_a || elig_b);

    // software configuration writes
    if (wr_ctrl) begin
      nxt_q.trig_a = bus_req_i.wdata[BIT_TRIG_A];
      nxt_q.trig_b = bus_req_i.wdata[BIT_TRIG_B];
    end
    if (wr_cfg) begin
      nxt_q.en_a = bus_req_i.wdata[BIT_EN_A];
      nxt_q.en_b = bus_req_i.wdata[BIT_EN_B];
      nxt_q.prio_a = bus_req_i.wdata[BIT_PRIO_A];
      nxt_q.prio_b = bus_req_i.wdata[BIT_PRIO_B];
      nxt_q.pd = bus_req_i.wdata[BIT_PD];
    end

    // a return closes the innermost routine, high before low
    if (ret_service_i) begin
      if (q_ff.svc_hi) begin
        nxt_q.svc_hi = 1'b0;
      end else begin
        nxt_q.svc_lo = 1'b0;
      end
    end

    // vector sequencer
    case (q_ff.st)
      ST_IDLE: begin
        // [RULE_03] the polling cycle is the detect cycle
        if (take) begin
          nxt_q.st = ST_CALL;
          nxt_q.cnt = 2'h0;
          nxt_q.src = sel_b;
          nxt_q.vprio = sel_b ? q_ff.prio_b : q_ff.prio_a;
          // [RULE_09] vectoring clears the edge flag
          hw_clr_a = !sel_b;
          hw_clr_b = sel_b;
        end
      end
      ST_CALL: begin
        // [RULE_03] four cycles of hardware_vector_call
        nxt_q.cnt = q_ff.cnt + 2'h1;
        if (q_ff.cnt == CALL_LAST) begin
          // [RULE_01] start lands five cycles after the poll
          nxt_q.st = ST_IDLE;
          nxt_q.start = 1'b1;
          if (q_ff.vprio) begin
            nxt_q.svc_hi = 1'b1;
          end else begin
            nxt_q.svc_lo = 1'b1;
          end
        end
      end
      default: begin
        // illegal code: fall back to idle
        nxt_q.st = ST_IDLE;
        nxt_q.cnt = 2'h0;
      end
    endcase

    // [RULE_10] level mode ignores the vector clear
    // [RULE_12] a pin left low keeps requesting
    nxt_q.flag_a = nxt_flag(q_ff.trig_a, smp_a.fall, smp_a.low, hw_clr_a, wr_ctrl,
                            bus_req_i.wdata[BIT_FLAG_A], q_ff.flag_a);
    nxt_q.flag_b = nxt_flag(q_ff.trig_b, smp_b.fall, smp_b.low, hw_clr_b, wr_ctrl,
                            bus_req_i.wdata[BIT_FLAG_B], q_ff.flag_b);

    // [RULE_13] a low pin ends power-down, over a write
    if (q_ff.pd && (smp_a.low || smp_b.low)) begin
      nxt_q.pd = 1'b0;
    end

    // [RULE_14] present flag and enable, no extra lag
    nxt_q.pend = {nxt_q.flag_b && nxt_q.en_b, nxt_q.flag_a && nxt_q.en_a};
    nxt_q.insvc = nxt_q.svc_lo || nxt_q.svc_hi;

    // register read, data valid only in the following cycle
    if (bus_req_i.rd) begin
      case (bus_req_i.addr)
        OFS_CTRL: begin
          nxt_q.rdata[BIT_TRIG_A] = q_ff.trig_a;
          nxt_q.rdata[BIT_FLAG_A] = q_ff.flag_a;
          nxt_q.rdata[BIT_TRIG_B] = q_ff.trig_b;
          nxt_q.rdata[BIT_FLAG_B] = q_ff.flag_b;
        end
        OFS_CFG: begin
          nxt_q.rdata[BIT_EN_A] = q_ff.en_a;
          nxt_q.rdata[BIT_EN_B] = q_ff.en_b;
          nxt_q.rdata[BIT_PRIO_A] = q_ff.prio_a;
          nxt_q.rdata[BIT_PRIO_B] = q_ff.prio_b;
          nxt_q.rdata[BIT_PD] = q_ff.pd;
        end
        OFS_STAT: begin
          nxt_q.rdata[BIT_CALLING] = (q_ff.st == ST_CALL);
          nxt_q.rdata[BIT_SVC_LO] = q_ff.svc_lo;
          nxt_q.rdata[BIT_SVC_HI] = q_ff.svc_hi;
          nxt_q.rdata[BIT_SRC] = q_ff.src;
          nxt_q.rdata[BIT_PD_ST] = q_ff.pd;
        end
        default: begin
          // unmapped offsets read as zero
          nxt_q.rdata = '0;
        end
      endcase
    end
  end

  // ==========================================================
  // state register
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      q_ff <= '{st: ST_IDLE, cnt: 2'h0,
                trig_a: RST_CTRL[BIT_TRIG_A], trig_b: RST_CTRL[BIT_TRIG_B],
                flag_a: RST_CTRL[BIT_FLAG_A], flag_b: RST_CTRL[BIT_FLAG_B],
                en_a: RST_CFG[BIT_EN_A], en_b: RST_CFG[BIT_EN_B],
                prio_a: RST_CFG[BIT_PRIO_A], prio_b: RST_CFG[BIT_PRIO_B],
                pd: RST_CFG[BIT_PD], default: '0};
    end else begin
      q_ff <= nxt_q;
    end
  end

  // ==========================================================
  // outputs, each straight from the state register
  assign rdata_o = q_ff.rdata;
  assign isr_start_o = q_ff.start;
  assign isr_src_o = q_ff.src;
  assign irq_pending_o = q_ff.pend;
  assign in_service_o = q_ff.insvc;
  assign power_down_o = q_ff.pd;

  // ==========================================================
  // assertions
  default clocking cb_eil @(posedge clk_i);
  endclocking
  default disable iff (!arst_n_i);

  // [RULE_01] start no sooner than five cycles
  a_min_latency: assert property (
    isr_start_o |-> $past(q_ff.st == ST_IDLE, 5) && $past(q_ff.st == ST_CALL, 4)) // [RULE_01]
    else $error("service start came too early");

  // [RULE_02] accepted request starts within bound
  a_start_bound: assert property (take |-> ##5 isr_start_o) // [RULE_02]
    else $error("service start missed its bound");

  // [RULE_03] detect then four call cycles
  a_call_length: assert property (
    take |=> (q_ff.st == ST_CALL) [*4] ##1 (q_ff.st == ST_IDLE)) // [RULE_03]
    else $error("vector call length is not four cycles");

  // [RULE_04] no vectoring mid instruction
  a_poll_end: assert property (
    (q_ff.st == ST_IDLE && !instr_end_i) |=> q_ff.st == ST_IDLE) // [RULE_04]
    else $error("vectored outside last instruction cycle");

  // [RULE_05] running high priority routine blocks all vectoring
  a_prio_block: assert property (
    (q_ff.svc_hi && q_ff.st == ST_IDLE) |=> q_ff.st == ST_IDLE) // [RULE_05]
    else $error("vectored over a high priority routine");

  // [RULE_07] edge mode sets the flag
  a_edge_set: assert property (
    (q_ff.trig_a && smp_a.fall) |=> q_ff.flag_a) // [RULE_07]
    else $error("falling edge did not set flag a");

  // [RULE_09] edge flag cleared on vectoring
  a_edge_clear: assert property (
    (take && !sel_b && q_ff.trig_a && !smp_a.fall && !wr_ctrl) |=> !q_ff.flag_a) // [RULE_09]
    else $error("edge flag a not cleared on vectoring");

  // [RULE_10] level flag tracks inverted pin
  a_level_follow: assert property (
    !q_ff.trig_b |=> q_ff.flag_b == $past(smp_b.low)) // [RULE_10]
    else $error("level flag b does not follow pin");

  // [RULE_12] low pin after return still requests
  a_level_again: assert property (
    (ret_service_i && !q_ff.trig_a && smp_a.low) |=> q_ff.flag_a) // [RULE_12]
    else $error("level request lost after return");

  // [RULE_13] pin activity wakes the device
  a_wake_pin: assert property (
    (q_ff.pd && (smp_a.low || smp_b.low)) |=> !power_down_o) // [RULE_13]
    else $error("pin did not wake from power-down");

  // [RULE_14] request gated by flag and enable
  a_pend_gate: assert property (
    irq_pending_o == {q_ff.flag_b && q_ff.en_b, q_ff.flag_a && q_ff.en_a}) // [RULE_14]
    else $error("pending request not flag and enable");

  // [RULE_03] start pulse lasts one cycle
  a_start_single: assert property (
    isr_start_o |=> !isr_start_o) // [RULE_03]
    else $error("service start pulse longer than one cycle");

  // [RULE_07] edge mode sets flag b
  a_edge_set_b: assert property (
    (q_ff.trig_b && smp_b.fall) |=> q_ff.flag_b) // [RULE_07]
    else $error("falling edge did not set flag b");

  // [RULE_09] vectoring clears edge flag b
  a_edge_clear_b: assert property (
    (take && sel_b && q_ff.trig_b && !smp_b.fall && !wr_ctrl) |=> !q_ff.flag_b) // [RULE_09]
    else $error("edge flag b not cleared on vectoring");

  // [RULE_10] level flag a tracks pin
  a_level_follow_a: assert property (
    !q_ff.trig_a |=> q_ff.flag_a == $past(smp_a.low)) // [RULE_10]
    else $error("level flag a does not follow pin");

endmodule // eil_ext_irq_unit

// File: verif/eil_pin_source.sv
// model of the external devices that drive the two request pins
module eil_pin_source (
  input wire logic clk_i, // system clock
  input wire logic arst_n_i, // asynchronous reset, active low
  input wire logic [1:0] pulse_i, // {b, a} start a short low pulse
  input wire logic [1:0] hold_i, // {b, a} hold the pin low
  output logic [1:0] pin_o // {b, a} request pins, active low
);
  timeunit 1ns;
  timeprecision 1ps;
  // ==========================================================
  // pulse timers
  logic [1:0] cnt_a_ff; // low cycles left on pin a
  logic [1:0] cnt_b_ff; // low cycles left on pin b

  // a pulse lasts three clocks so a two-flop sampler can never miss it
  // low level held three clocks
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      cnt_a_ff <= 2'h0;
      cnt_b_ff <= 2'h0;
    end else begin
      cnt_a_ff <= pulse_i[0] ? 2'h3 : (cnt_a_ff != 2'h0 ? cnt_a_ff - 2'h1 : 2'h0);
      cnt_b_ff <= pulse_i[1] ? 2'h3 : (cnt_b_ff != 2'h0 ? cnt_b_ff - 2'h1 : 2'h0);
    end
  end

  // pins idle high; a level source keeps its pin low until told to let go
  // hold low until serviced
  // one driver for the whole pin vector, bit 1 is pin b
  assign pin_o = {!(hold_i[1] || cnt_b_ff != 2'h0), !(hold_i[0] || cnt_a_ff != 2'h0)};
endmodule // eil_pin_source

// File: verif/tb_top.sv
// self-checking bench for the external request pin interrupt unit
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import eil_pkg::*;
  // ==========================================================
  // signals
  logic clk_i; // system clock
  logic arst_n_i; // reset, active low
  eil_bus_req_s bus_req; // register access
  logic [7:0] rdata; // read data
  logic [1:0] pins; // request pins {b, a}
  logic [1:0] pulse; // partner pulse commands
  logic [1:0] hold; // partner hold commands
  logic instr_end; // last cycle of instruction
  logic ret_svc; // return from service
  logic isr_start; // routine start pulse
  logic isr_src; // routine source
  logic [1:0] pend; // presented requests
  logic in_svc; // routine running
  logic pd; // powered down
  int bad_count; // mismatches
  int num_checks; // comparisons
  int n; // cycle count

  eil_ext_irq_unit eil_ext_irq_unit_inst (
    .clk_i(clk_i), .arst_n_i(arst_n_i), .bus_req_i(bus_req), .rdata_o(rdata),
    .ext_req_pin_a_i(pins[0]), .ext_req_pin_b_i(pins[1]), .instr_end_i(instr_end),
    .ret_service_i(ret_svc), .isr_start_o(isr_start), .isr_src_o(isr_src),
    .irq_pending_o(pend), .in_service_o(in_svc), .power_down_o(pd));

  eil_pin_source eil_pin_source_inst (
    .clk_i(clk_i), .arst_n_i(arst_n_i), .pulse_i(pulse), .hold_i(hold), .pin_o(pins));

  // ==========================================================
  // clock, 40 ns period
  initial begin
    clk_i = 1'b0;
    forever #(CLK_PERIOD_NS / 2) clk_i = ~clk_i;
  end

  // ==========================================================
  // helpers
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // settle after an edge before looking at registered outputs
  task automatic tick(input int k);
    repeat (k) @(posedge clk_i);
    #1;
  endtask

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk_i);
    bus_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk_i);
    bus_req.wr <= 1'b0;
  endtask

  // read data stand only in the cycle after the strobe
  task automatic rd_chk(input logic [3:0] a, input logic [7:0] exp);
    @(posedge clk_i);
    bus_req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge clk_i);
    bus_req.rd <= 1'b0;
    #1;
    check(rdata, exp);
  endtask

  task automatic strobe_pulse(input int i);
    @(posedge clk_i);
    pulse[i] <= 1'b1;
    @(posedge clk_i);
    pulse[i] <= 1'b0;
  endtask

  task automatic ret();
    @(posedge clk_i);
    ret_svc <= 1'b1;
    @(posedge clk_i);
    ret_svc <= 1'b0;
  endtask

  // count edges until a routine starts, bounded so a hang cannot stall
  task automatic wait_start(output int k);
    k = 0;
    do begin
      tick(1);
      k++;
    end while (isr_start !== 1'b1 && k < 40);
  endtask

  // poll opened at an edge, start must follow exactly five edges later
  task automatic poll_now();
    @(posedge clk_i);
    instr_end <= 1'b1;
    wait_start(n);
  endtask

  // ==========================================================
  // scenarios
  task automatic t_reset();
    rd_chk(OFS_CTRL, RST_CTRL);
    rd_chk(OFS_CFG, RST_CFG);
    rd_chk(OFS_STAT, 8'h00);
    rd_chk(4'h7, 8'h00);
    check({3'h0, pend, in_svc, pd, isr_start}, 8'h00);
  endtask

  task automatic t_edge();
    wr(OFS_CTRL, 8'h05);
    strobe_pulse(0);
    tick(6);
    rd_chk(OFS_CTRL, 8'h07);
    check({6'h0, pend}, 8'h00);
    wr(OFS_CFG, 8'h03);
    tick(1);
    check({6'h0, pend}, 8'h01);
    poll_now();
    check(8'(n), 8'(MIN_RESPONSE_CYC));
    check({6'h0, isr_src, in_svc}, 8'h01);
    rd_chk(OFS_CTRL, 8'h05);
  endtask

  // routine for a runs at low priority, so b must wait for the return
  task automatic t_nest();
    strobe_pulse(1);
    wait_start(n);
    check(8'(n), 8'd40);
    check({6'h0, pend}, 8'h02);
    ret();
    wait_start(n);
    check({6'h0, isr_start, isr_src}, 8'h03);
    ret();
    tick(2);
    check({7'h0, in_svc}, 8'h00);
  endtask

  task automatic t_defer();
    @(posedge clk_i);
    instr_end <= 1'b0;
    strobe_pulse(0);
    tick(6);
    wait_start(n);
    check(8'(n), 8'd40);
    poll_now();
    check(8'(n), 8'(MIN_RESPONSE_CYC));
    ret();
  endtask

  // b at high priority breaks into a low routine but never into a high one
  task automatic t_prio();
    wr(OFS_CFG, 8'h0b);
    strobe_pulse(0);
    wait_start(n);
    check({6'h0, isr_start, isr_src}, 8'h02);
    strobe_pulse(1);
    wait_start(n);
    check({6'h0, isr_start, isr_src}, 8'h03);
    rd_chk(OFS_STAT, 8'h0e);
    strobe_pulse(1);
    wait_start(n);
    check(8'(n), 8'd40);
    check({6'h0, pend}, 8'h02);
    ret();
    wait_start(n);
    check(8'(n), 8'(MIN_RESPONSE_CYC));
    ret();
    ret();
    tick(2);
    check({7'h0, in_svc}, 8'h00);
    wr(OFS_CFG, 8'h03);
  endtask

  // every cycle ends an instruction, so pin to start stays inside the bound
  task automatic t_worst();
    tick(3);
    strobe_pulse(0);
    wait_start(n);
    check(8'(n < MIN_RESPONSE_CYC || n > MAX_RESPONSE_CYC), 8'h00);
    ret();
    tick(2);
  endtask

  task automatic t_level();
    @(posedge clk_i);
    instr_end <= 1'b0;
    wr(OFS_CTRL, 8'h04);
    hold[0] <= 1'b1;
    tick(6);
    rd_chk(OFS_CTRL, 8'h06);
    poll_now();
    check(8'(n), 8'(MIN_RESPONSE_CYC));
    rd_chk(OFS_CTRL, 8'h06);
    ret();
    wait_start(n);
    check({6'h0, isr_start, isr_src}, 8'h02);
    @(posedge clk_i);
    hold[0] <= 1'b0;
    tick(6);
    rd_chk(OFS_CTRL, 8'h04);
    ret();
    wait_start(n);
    check(8'(n), 8'd40);
    check({7'h0, in_svc}, 8'h00);
  endtask

  task automatic t_wake();
    wr(OFS_CFG, 8'h13);
    tick(1);
    check({7'h0, pd}, 8'h01);
    rd_chk(OFS_STAT, 8'h10);
    strobe_pulse(1);
    tick(6);
    check({7'h0, pd}, 8'h00);
  endtask

  // ==========================================================
  // verdict, reached from the main sequence or the watchdog
  task automatic final_report();
    $display("checks=%0d mismatches=%0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // main sequence
  initial begin
    bad_count = 0;
    num_checks = 0;
    arst_n_i = 1'b0;
    bus_req = '0;
    pulse = 2'b00;
    hold = 2'b00;
    instr_end = 1'b0;
    ret_svc = 1'b0;
    repeat (12) @(posedge clk_i);
    arst_n_i <= 1'b1;
    t_reset();
    t_edge();
    t_nest();
    t_defer();
    t_prio();
    t_worst();
    t_level();
    t_wake();
    final_report();
  end

  // watchdog: whole run needs well under a thousand cycles
  initial begin
    #(CLK_PERIOD_NS * 5000);
    bad_count++;
    final_report();
  end
endmodule // tb_top
